// ---- src/dios_pkg.sv ----
// package: register map, field positions, reset values and timing constants
package dios_pkg;
	// register byte offsets
	localparam logic [7:0] ADDR_OUT_STATUS = 8'h00;
	localparam logic [7:0] ADDR_POLARITY = 8'h04;
	localparam logic [7:0] ADDR_OH_SEL = 8'h08;
	localparam logic [7:0] ADDR_MOT_TRIP = 8'h0C;
	localparam logic [7:0] ADDR_FAN_CTRL = 8'h10;
	localparam logic [7:0] ADDR_UNIT_CTRL = 8'h14;
	localparam logic [7:0] ADDR_COMM_CFG = 8'h18;
	localparam logic [7:0] ADDR_COMM_TIMEOUT = 8'h1C;
	localparam logic [7:0] ADDR_RELAY_DELAY = 8'h20;
	localparam logic [7:0] ADDR_CHECK_TIME = 8'h24;
	localparam logic [7:0] ADDR_STATUS = 8'h28;
	localparam logic [7:0] ADDR_INPUTS = 8'h2C;
	localparam logic [7:0] ADDR_SCALED = 8'h30;
	// reset values and write limits
	localparam logic [10:0] POLARITY_RST = 11'h000;
	localparam logic [2:0] OH_SEL_RST = 3'h7;
	localparam logic [8:0] MOT_TRIP_RST = 9'h06E;
	localparam logic [7:0] STATION_RST = 8'h01;
	localparam logic [2:0] BAUD_RST = 3'h3;
	localparam logic [15:0] TIMEOUT_RST = 16'h000A;
	localparam logic [10:0] TURN_DLY_RST = 11'h005;
	localparam logic [10:0] TURN_DLY_MIN = 11'h002;
	localparam logic [10:0] TURN_DLY_MAX = 11'h4B0;
	localparam logic [7:0] STATION_MAX = 8'hFA;
	localparam logic [15:0] CHECK_RST = 16'h0001;
	localparam logic [2:0] UNIT_MAX_CODE = 3'h5;
	// overheat select bit positions (stored bits 1..3 as [0..2])
	localparam int OH_MOTOR_BIT = 0;
	localparam int OH_EXT_BIT = 2;
	// timing: ms tick base and 100 ms tenth-second base
	localparam int CLK_HZ = 125000000;
	localparam int MS_NS = 1000000;
	localparam int CLK_NS = 8;
	localparam int MS_CYCLES = MS_NS / CLK_NS;
	localparam int TENTH_MS = 100;
	// baud, fan mode and loss action codes
	typedef enum logic [2:0] {
		DIOS_B1200, DIOS_B2400, DIOS_B4800, DIOS_B9600, DIOS_B19200,
		DIOS_B38400
	} dios_baud_t;
	typedef enum logic [1:0] {
		DIOS_FAN_POWER, DIOS_FAN_RUN, DIOS_FAN_TEMP
	} dios_fan_t;
	typedef enum logic [1:0] {
		DIOS_LOSS_NONE, DIOS_LOSS_COAST, DIOS_LOSS_STOP
	} dios_loss_t;
endpackage

// ---- src/dios_top.sv ----
// drive terminal and serial link supervision with an axi4-lite slave
//
// Summary of operation
// - fault relay switches on and off after separate delays, both default zero
// - fan mode 0 keeps fan on whenever powered
// - fan mode 1 runs fan only while drive outputs frequency
// - fan mode 2 runs fan only above fan temperature threshold
// - fan settings exist only on ratings of 37kW and above
// - unit code 0..5 selects percent, bar, mbar, kpa, psi, pa
// - process control off forces unit code back to percent
// - displayed process value scaled so unit maximum equals maximum frequency
// - station id 1..250, default 1
// - baud one of six rates, default 9600, same at both ends
// - loss handling only with serial command or reference source; show remote
// - loss declared when no valid traffic within timeout, default one second
// - loss action none keeps running
// - loss action coast cuts output at once
// - loss action stop decelerates by configured pattern
// - turnaround delay 2..1200 ms, default 5 ms
// - per-terminal polarity, 0 normally open, 1 normally closed
// - extension inputs usable only with sub-board installed
// - multi-step inputs accepted only after stable for check time
// - motor overheat trips at threshold when enabled, default 110
// - select bit 2 reserved, bit 1 motor trip, bit 3 external sensor
// - heat sink overheat protection always active
//
// The AXI4-Lite interface to the registers and the register offsets were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module dios_top #(
	parameter bit LARGE_RATING = 1'b1,
	parameter int MS_CYC = dios_pkg::MS_CYCLES
) (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic [31:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [31:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [7:0] multi_input_pins,
	input wire logic [2:0] extension_input_pins,
	input wire logic sub_board_present,
	input wire logic [3:0] aux_relay_state,
	input wire logic [2:0] open_collector_state,
	input wire logic fault_active,
	input wire logic drive_running,
	input wire logic [8:0] drive_temp,
	input wire logic [8:0] motor_temp,
	input wire logic heatsink_overheat,
	input wire logic multi_step_active,
	input wire logic serial_cmd_source,
	input wire logic serial_ref_source,
	input wire logic frame_valid,
	input wire logic frame_end,
	input wire logic [15:0] process_value,
	input wire logic [15:0] max_freq,
	output logic fault_relay_contact,
	output logic cooling_fan_on,
	output logic remote_state_indicator,
	output logic comm_lost,
	output logic output_cutoff,
	output logic decel_stop_req,
	output logic motor_overheat_trip,
	output logic heatsink_trip,
	output logic [10:0] valid_inputs,
	output logic tx_enable,
	output logic [7:0] station_id,
	output logic [2:0] baud_sel
);
	// ==========================================================
	// register state
	logic [10:0] polarity_r;
	logic [2:0] oh_sel_r;
	logic [8:0] mot_trip_r, fan_temp_r;
	logic [1:0] fan_mode_r, loss_mode_r;
	logic [2:0] unit_r;
	logic proc_en_r;
	logic [15:0] unit_max_r, timeout_r, check_r;
	logic [7:0] station_r;
	logic [2:0] baud_r;
	logic [10:0] turn_dly_r;
	logic [15:0] on_dly_r, off_dly_r;
	logic [7:0] out_status_r;

	// ==========================================================
	// pin synchronisers
	logic [13:0] sync1_r, sync2_r;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			sync1_r <= 14'h0000;
			sync2_r <= 14'h0000;
		end else begin
			sync1_r <= {frame_end, frame_valid, sub_board_present,
				extension_input_pins, multi_input_pins};
			sync2_r <= sync1_r;
		end
	end
	wire logic [10:0] pins_s = sync2_r[10:0];
	wire logic board_s = sync2_r[11];
	wire logic frame_s = sync2_r[12];
	wire logic fend_s = sync2_r[13];

	// ==========================================================
	// millisecond tick shared by all timers
	logic [31:0] ms_cnt_r;
	logic ms_tick;
	assign ms_tick = (ms_cnt_r == 32'(MS_CYC - 1));
	always_ff @(posedge ref_clk) begin
		if (!rstn) ms_cnt_r <= 32'h0;
		else ms_cnt_r <= ms_tick ? 32'h0 : ms_cnt_r + 32'h1;
	end

	// ==========================================================
	// input polarity and check time
	logic [10:0] logical_in, cand_r, valid_r;
	logic [15:0] stab_r;
	always_comb begin
		logical_in = pins_s ^ polarity_r;
		if (!board_s) logical_in[10:8] = 3'h0;
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			cand_r <= 11'h000;
			valid_r <= 11'h000;
			stab_r <= 16'h0;
		end else if (!multi_step_active) begin
			cand_r <= logical_in;
			valid_r <= logical_in;
			stab_r <= 16'h0;
		end else if (logical_in != cand_r) begin
			cand_r <= logical_in;
			stab_r <= 16'h0;
		end else if (stab_r > check_r) begin
			valid_r <= cand_r;
		end else if (ms_tick) begin
			stab_r <= stab_r + 16'h1;
		end
	end
	assign valid_inputs = valid_r;

	// ==========================================================
	// fault relay on/off delays in tenths of a second
	logic [31:0] rly_cnt_r;
	logic rly_r;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			rly_r <= 1'b0;
			rly_cnt_r <= 32'h0;
		end else if (fault_active == rly_r) begin
			rly_cnt_r <= 32'h0;
		end else if (rly_cnt_r >= 32'(fault_active ? on_dly_r : off_dly_r)
				* 32'(dios_pkg::TENTH_MS)) begin
			rly_r <= fault_active;
			rly_cnt_r <= 32'h0;
		end else if (ms_tick) begin
			rly_cnt_r <= rly_cnt_r + 32'h1;
		end
	end
	assign fault_relay_contact = rly_r;

	// ==========================================================
	// status word and fan
	always_ff @(posedge ref_clk) begin
		if (!rstn) out_status_r <= 8'h00;
		else out_status_r <= {rly_r, open_collector_state,
			aux_relay_state};
	end
	always_ff @(posedge ref_clk) begin
		if (!rstn) cooling_fan_on <= 1'b1;
		else if (!LARGE_RATING) cooling_fan_on <= 1'b1;
		else begin
			case (fan_mode_r)
			2'h0: cooling_fan_on <= 1'b1;
			2'h1: cooling_fan_on <= drive_running;
			2'h2: cooling_fan_on <= drive_temp > fan_temp_r;
			default: cooling_fan_on <= 1'b1;
			endcase
		end
	end

	// ==========================================================
	// overheat protection
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			motor_overheat_trip <= 1'b0;
			heatsink_trip <= 1'b0;
		end else begin
			motor_overheat_trip <= oh_sel_r[dios_pkg::OH_MOTOR_BIT] &&
				motor_temp >= mot_trip_r;
			heatsink_trip <= heatsink_overheat;
		end
	end

	// ==========================================================
	// process display scaling: value * unit_max / max_freq
	logic [15:0] scaled_r;
	always_ff @(posedge ref_clk) begin
		if (!rstn) scaled_r <= 16'h0;
		else if (max_freq == 16'h0) scaled_r <= 16'h0;
		else scaled_r <= 16'((32'(process_value) * 32'(unit_max_r))
			/ 32'(max_freq));
	end

	// ==========================================================
	// communication loss watchdog (timeout in tenths of a second)
	logic serial_mode, lost_r;
	logic [31:0] wd_cnt_r;
	assign serial_mode = serial_cmd_source | serial_ref_source;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			wd_cnt_r <= 32'h0;
			lost_r <= 1'b0;
		end else if (!serial_mode || frame_s) begin
			wd_cnt_r <= 32'h0;
			lost_r <= 1'b0;
		// strictly past the limit: the shared tick may land early
		end else if (wd_cnt_r > 32'(timeout_r) * 32'(dios_pkg::TENTH_MS)) begin
			lost_r <= 1'b1;
		end else if (ms_tick) begin
			wd_cnt_r <= wd_cnt_r + 32'h1;
		end
	end
	// a stale loss flag must not outlive remote mode by a cycle
	assign comm_lost = lost_r && serial_mode;
	assign remote_state_indicator = serial_mode;
	assign output_cutoff = comm_lost &&
		loss_mode_r == 2'(dios_pkg::DIOS_LOSS_COAST);
	// none leaves both actions low
	assign decel_stop_req = comm_lost &&
		loss_mode_r == 2'(dios_pkg::DIOS_LOSS_STOP);

	// ==========================================================
	// turnaround delay before reply transmit
	logic [10:0] ta_cnt_r;
	logic ta_busy_r;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			ta_busy_r <= 1'b0;
			ta_cnt_r <= 11'h0;
			tx_enable <= 1'b0;
		end else if (fend_s) begin
			ta_busy_r <= 1'b1;
			ta_cnt_r <= 11'h0;
			tx_enable <= 1'b0;
		end else if (ta_busy_r && ta_cnt_r > turn_dly_r) begin
			ta_busy_r <= 1'b0;
			tx_enable <= 1'b1;
		end else if (ta_busy_r && ms_tick) begin
			ta_cnt_r <= ta_cnt_r + 11'h1;
		end else if (frame_s) begin
			tx_enable <= 1'b0;
		end
	end
	assign station_id = station_r;
	assign baud_sel = baud_r;

	// ==========================================================
	// axi4-lite write channel
	logic aw_ok_r, w_ok_r;
	logic [7:0] aw_r;
	logic [31:0] wd_r;
	logic do_wr;
	assign s_axi_awready = !aw_ok_r && !s_axi_bvalid;
	assign s_axi_wready = !w_ok_r && !s_axi_bvalid;
	assign do_wr = aw_ok_r && w_ok_r;
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			aw_ok_r <= 1'b0;
			w_ok_r <= 1'b0;
			aw_r <= 8'h0;
			wd_r <= 32'h0;
			s_axi_bvalid <= 1'b0;
			s_axi_bresp <= 2'h0;
		end else begin
			if (s_axi_awvalid && s_axi_awready) begin
				aw_ok_r <= 1'b1;
				aw_r <= s_axi_awaddr[7:0];
			end
			if (s_axi_wvalid && s_axi_wready) begin
				w_ok_r <= 1'b1;
				wd_r <= s_axi_wdata;
			end
			if (do_wr) begin
				aw_ok_r <= 1'b0;
				w_ok_r <= 1'b0;
				s_axi_bvalid <= 1'b1;
				s_axi_bresp <= (aw_r <= dios_pkg::ADDR_CHECK_TIME &&
					aw_r[1:0] == 2'h0) ? 2'h0 : 2'h2;
			end else if (s_axi_bvalid && s_axi_bready) begin
				s_axi_bvalid <= 1'b0;
			end
		end
	end

	// ==========================================================
	// configuration registers; any nonzero strobe writes the whole word, an all-zero strobe drops the write
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			polarity_r <= dios_pkg::POLARITY_RST;
			oh_sel_r <= dios_pkg::OH_SEL_RST;
			mot_trip_r <= dios_pkg::MOT_TRIP_RST;
			fan_mode_r <= 2'h0;
			fan_temp_r <= 9'h03C;
			unit_r <= 3'h0;
			proc_en_r <= 1'b0;
			unit_max_r <= 16'h0064;
			station_r <= dios_pkg::STATION_RST;
			baud_r <= dios_pkg::BAUD_RST;
			loss_mode_r <= 2'h0;
			timeout_r <= dios_pkg::TIMEOUT_RST;
			turn_dly_r <= dios_pkg::TURN_DLY_RST;
			on_dly_r <= 16'h0;
			off_dly_r <= 16'h0;
			check_r <= dios_pkg::CHECK_RST;
		end else begin
			if (!proc_en_r) unit_r <= 3'h0;
			if (do_wr && s_axi_wstrb != 4'h0) begin
				case (aw_r)
				dios_pkg::ADDR_POLARITY: polarity_r <= wd_r[10:0];
				dios_pkg::ADDR_OH_SEL: oh_sel_r <= wd_r[2:0];
				dios_pkg::ADDR_MOT_TRIP: mot_trip_r <= wd_r[8:0];
				dios_pkg::ADDR_FAN_CTRL: begin
					if (LARGE_RATING) begin
						fan_mode_r <= (wd_r[1:0] == 2'h3) ? fan_mode_r : wd_r[1:0];
						fan_temp_r <= wd_r[16:8];
					end
				end
				dios_pkg::ADDR_UNIT_CTRL: begin
					proc_en_r <= wd_r[3];
					if (wd_r[3] && wd_r[2:0] <= dios_pkg::UNIT_MAX_CODE)
						unit_r <= wd_r[2:0];
					unit_max_r <= wd_r[31:16];
				end
				dios_pkg::ADDR_COMM_CFG: begin
					if (wd_r[7:0] != 8'h0 && wd_r[7:0] <= dios_pkg::STATION_MAX)
						station_r <= wd_r[7:0];
					if (wd_r[10:8] <= 3'h5) baud_r <= wd_r[10:8];
					if (wd_r[13:12] != 2'h3) loss_mode_r <= wd_r[13:12];
					if (wd_r[26:16] >= dios_pkg::TURN_DLY_MIN &&
							wd_r[26:16] <= dios_pkg::TURN_DLY_MAX)
						turn_dly_r <= wd_r[26:16];
				end
				dios_pkg::ADDR_COMM_TIMEOUT: timeout_r <= wd_r[15:0];
				dios_pkg::ADDR_RELAY_DELAY: begin
					on_dly_r <= wd_r[15:0];
					off_dly_r <= wd_r[31:16];
				end
				dios_pkg::ADDR_CHECK_TIME: check_r <= wd_r[15:0];
				default: ;
				endcase
			end
		end
	end

	// ==========================================================
	// axi4-lite read channel
	always_ff @(posedge ref_clk) begin
		if (!rstn) begin
			s_axi_arready <= 1'b0;
			s_axi_rvalid <= 1'b0;
			s_axi_rdata <= 32'h0;
			s_axi_rresp <= 2'h0;
		end else begin
			s_axi_arready <= 1'b0;
			if (s_axi_rvalid && s_axi_rready) s_axi_rvalid <= 1'b0;
			if (s_axi_arvalid && !s_axi_arready && !s_axi_rvalid) begin
				s_axi_arready <= 1'b1;
				s_axi_rvalid <= 1'b1;
				s_axi_rresp <= 2'h0;
				case (s_axi_araddr[7:0])
				dios_pkg::ADDR_OUT_STATUS: s_axi_rdata <= {24'h0, out_status_r};
				dios_pkg::ADDR_POLARITY: s_axi_rdata <= {21'h0, polarity_r};
				dios_pkg::ADDR_OH_SEL: s_axi_rdata <= {29'h0, oh_sel_r};
				dios_pkg::ADDR_MOT_TRIP: s_axi_rdata <= {23'h0, mot_trip_r};
				dios_pkg::ADDR_FAN_CTRL: s_axi_rdata <= LARGE_RATING ?
					{15'h0, fan_temp_r, 6'h0, fan_mode_r} : 32'h0;
				dios_pkg::ADDR_UNIT_CTRL: s_axi_rdata <=
					{unit_max_r, 12'h0, proc_en_r, unit_r};
				dios_pkg::ADDR_COMM_CFG: s_axi_rdata <= {5'h0, turn_dly_r,
					2'h0, loss_mode_r, 1'b0, baud_r, station_r};
				dios_pkg::ADDR_COMM_TIMEOUT: s_axi_rdata <= {16'h0, timeout_r};
				dios_pkg::ADDR_RELAY_DELAY: s_axi_rdata <= {off_dly_r, on_dly_r};
				dios_pkg::ADDR_CHECK_TIME: s_axi_rdata <= {16'h0, check_r};
				dios_pkg::ADDR_STATUS: s_axi_rdata <= {24'h0, tx_enable,
					heatsink_trip, motor_overheat_trip, decel_stop_req,
					output_cutoff, lost_r, serial_mode, cooling_fan_on};
				dios_pkg::ADDR_INPUTS: s_axi_rdata <= {21'h0, valid_r};
				dios_pkg::ADDR_SCALED: s_axi_rdata <= {16'h0, scaled_r};
				default: begin
					s_axi_rdata <= 32'h0;
					s_axi_rresp <= 2'h2;
				end
				endcase
			end
		end
	end
endmodule // dios_top
`default_nettype wire

// ---- test/dios_chk_sva.sv ----
// checker: port-level assertions for the supervision block
`timescale 1ns/1ps
`default_nettype none
module dios_chk (
	input wire logic ref_clk,
	input wire logic rstn,
	input wire logic serial_cmd_source,
	input wire logic serial_ref_source,
	input wire logic remote_state_indicator,
	input wire logic comm_lost,
	input wire logic output_cutoff,
	input wire logic decel_stop_req,
	input wire logic heatsink_overheat,
	input wire logic heatsink_trip,
	input wire logic [7:0] station_id,
	input wire logic [2:0] baud_sel,
	input wire logic s_axi_arvalid,
	input wire logic s_axi_arready,
	input wire logic s_axi_rvalid,
	input wire logic s_axi_rready,
	input wire logic [31:0] s_axi_rdata
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// ====================================
	// serial supervision
	AST_REMOTE: assert property (
		remote_state_indicator == (serial_cmd_source | serial_ref_source))
		else $error("remote indicator differs from sources");
	AST_LOST_REMOTE: assert property (
		comm_lost |-> remote_state_indicator)
		else $error("loss declared while not remote");
	AST_ACT_CAUSE: assert property (
		(output_cutoff || decel_stop_req) |-> comm_lost)
		else $error("loss reaction without loss");
	AST_ACT_ONE: assert property (
		!(output_cutoff && decel_stop_req))
		else $error("coast and stop together");
	AST_STATION: assert property (
		station_id inside {[8'h01:8'hFA]})
		else $error("station id out of range");
	AST_BAUD: assert property (
		baud_sel <= 3'h5)
		else $error("baud code out of range");
	// ====================================
	// protection and bus
	AST_HS_TRIP: assert property (
		$rose(heatsink_overheat) |-> ##[1:3] heatsink_trip)
		else $error("heat sink trip missing");
	AST_R_HOLD: assert property (
		s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
		else $error("read answer dropped or changed");
	AST_R_ANSWER: assert property (
		s_axi_arvalid && !s_axi_rvalid && !s_axi_arready |=> s_axi_rvalid)
		else $error("read answer late");
endmodule // dios_chk
bind dios_top dios_chk u_chk (.ref_clk, .rstn, .serial_cmd_source,
	.serial_ref_source, .remote_state_indicator, .comm_lost, .output_cutoff,
	.decel_stop_req, .heatsink_overheat, .heatsink_trip, .station_id,
	.baud_sel, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid, .s_axi_rready,
	.s_axi_rdata);
`default_nettype wire

// ---- test/dios_host_model.sv ----
// host model: sends one serial frame per request on the shared line
`timescale 1ns/1ps
`default_nettype none
module dios_host_model #(
	parameter int BIT_CYC = 4
) (
	input wire logic ref_clk,
	input wire logic send,
	output logic frame_valid,
	output logic frame_end
);
	int cnt = 0;
	initial frame_valid = 1'h0;
	initial frame_end = 1'h0;
	// ====================================
	// frame timing: eleven bit times at the agreed rate, then end marker
	always @(posedge ref_clk) begin
		if (send && cnt == 0)
			cnt <= 11 * BIT_CYC + 3;
		else if (cnt != 0)
			cnt <= cnt - 1;
		frame_valid <= (cnt > 3);
		frame_end <= (cnt inside {[1:3]});
	end
endmodule // dios_host_model
`default_nettype wire

// ---- test/tb_top.sv ----
// testbench: registers, terminals, fan, relay and serial-loss scenarios
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	// ====================================
	// stimulus and design
	logic ref_clk = 1'h0;
	logic rstn = 1'h0;
	logic [31:0] s_axi_awaddr = 32'h0, s_axi_wdata = 32'h0;
	logic [31:0] s_axi_araddr = 32'h0, r1, r2;
	logic [3:0] s_axi_wstrb = 4'hF, aux_relay_state = 4'h0;
	logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
	logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0, send = 1'h0;
	logic [7:0] multi_input_pins = 8'h0;
	logic [2:0] extension_input_pins = 3'h0, open_collector_state = 3'h0;
	logic [8:0] drive_temp = 9'h0, motor_temp = 9'h0;
	logic [15:0] process_value = 16'h0, max_freq = 16'h64;
	logic sub_board_present = 1'h0, fault_active = 1'h0;
	logic drive_running = 1'h0, heatsink_overheat = 1'h0;
	logic multi_step_active = 1'h0, serial_cmd_source = 1'h0;
	logic serial_ref_source = 1'h0;
	wire logic frame_valid, frame_end, s_axi_awready, s_axi_wready;
	wire logic s_axi_bvalid, s_axi_arready, s_axi_rvalid, comm_lost;
	wire logic fault_relay_contact, cooling_fan_on, remote_state_indicator;
	wire logic output_cutoff, decel_stop_req, motor_overheat_trip;
	wire logic heatsink_trip, tx_enable;
	wire logic [1:0] s_axi_bresp, s_axi_rresp;
	wire logic [31:0] s_axi_rdata;
	wire logic [10:0] valid_inputs;
	wire logic [7:0] station_id;
	wire logic [2:0] baud_sel;
	dios_top #(.MS_CYC(10)) u_dut (.ref_clk, .rstn, .s_axi_awaddr,
		.s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
		.s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
		.s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
		.s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
		.multi_input_pins, .extension_input_pins, .sub_board_present,
		.aux_relay_state, .open_collector_state, .fault_active, .drive_running,
		.drive_temp, .motor_temp, .heatsink_overheat, .multi_step_active,
		.serial_cmd_source, .serial_ref_source, .frame_valid, .frame_end,
		.process_value, .max_freq, .fault_relay_contact, .cooling_fan_on,
		.remote_state_indicator, .comm_lost, .output_cutoff, .decel_stop_req,
		.motor_overheat_trip, .heatsink_trip, .valid_inputs, .tx_enable,
		.station_id, .baud_sel);
	dios_host_model #(.BIT_CYC(4)) u_host (.ref_clk, .send, .frame_valid,
		.frame_end);
	initial forever #4 ref_clk = ~ref_clk;
	// ====================================
	// expectations, comparison and verdict
	logic [33:0] exp_q[$], msk_q[$];
	int mismatches = 0, check_count = 0, cyc = 0;
	task automatic end_sim;
		$display("checks %0d mismatches %0d", check_count, mismatches);
		if (mismatches == 0 && check_count > 0)
			$display("RESULT: PASS");
		else
			$display("RESULT: FAIL");
		$finish;
	endtask
	task automatic cmp(input logic [33:0] got);
		logic [33:0] e, m;
		e = exp_q.pop_front();
		m = msk_q.pop_front();
		check_count++;
		if ((got & m) !== (e & m)) begin
			mismatches++;
			$display("BAD t=%0t got=%h exp=%h", $time, got & m, e & m);
		end
	endtask
	task automatic cmp_wr(input logic [1:0] got);
		cmp({got, 32'h0});
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (s_axi_rvalid && s_axi_rready)
			cmp({s_axi_rresp, s_axi_rdata});
		if (s_axi_bvalid && s_axi_bready)
			cmp_wr(s_axi_bresp);
		if (cyc == 8000) begin
			mismatches++;
			end_sim();
		end
	end
	// ====================================
	// bus tasks: release each channel when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] d,
		input logic [1:0] r = 2'h0);
		exp_q.push_back({r, 32'h0});
		msk_q.push_back({2'h3, 32'h0});
		@(posedge ref_clk);
		s_axi_awaddr <= {24'h0, a};
		s_axi_wdata <= d;
		s_axi_awvalid <= 1'h1;
		s_axi_wvalid <= 1'h1;
		s_axi_bready <= 1'h1;
		do begin
			@(posedge ref_clk);
			if (s_axi_awready)
				s_axi_awvalid <= 1'h0;
			if (s_axi_wready)
				s_axi_wvalid <= 1'h0;
		end while (s_axi_bvalid !== 1'h1);
		s_axi_bready <= 1'h0;
	endtask
	task automatic rd(input logic [7:0] a, input logic [31:0] e,
		input logic [31:0] m = 32'hFFFFFFFF, input logic [1:0] r = 2'h0,
		input logic slow = 1'h0);
		exp_q.push_back({r, e});
		msk_q.push_back({2'h3, m});
		@(posedge ref_clk);
		s_axi_araddr <= {24'h0, a};
		s_axi_arvalid <= 1'h1;
		s_axi_rready <= !slow;
		do @(posedge ref_clk); while (s_axi_rvalid !== 1'h1);
		s_axi_arvalid <= 1'h0;
		// a late rready makes the slave hold its answer a cycle
		if (slow) begin
			s_axi_rready <= 1'h1;
			@(posedge ref_clk);
		end
		s_axi_rready <= 1'h0;
	endtask
	// ====================================
	// scenarios
	initial begin
		r1 = $urandom(32'h9139A121);
		repeat (6) @(posedge ref_clk);
		rstn <= 1'h1;
		rd(8'h04, 32'h0);
		rd(8'h08, 32'h7);
		rd(8'h0C, 32'h6E);
		rd(8'h18, 32'h00050301);
		rd(8'h1C, 32'hA);
		rd(8'h20, 32'h0);
		rd(8'h24, 32'h1, 32'hFFFFFFFF, 2'h0, 1'h1);
		rd(8'h34, 32'h0, 32'hFFFFFFFF, 2'h2);
		wr(8'h40, 32'h1, 2'h2);
		rd(8'h28, 32'h1, 32'h1);
		wr(8'h10, 32'h3C01);
		rd(8'h28, 32'h0, 32'h1);
		drive_running <= 1'h1;
		rd(8'h28, 32'h1, 32'h1);
		wr(8'h10, 32'h3C02);
		drive_temp <= 9'h3D;
		rd(8'h28, 32'h1, 32'h1);
		drive_temp <= 9'h3C;
		rd(8'h28, 32'h0, 32'h1);
		wr(8'h10, 32'h3C00);
		drive_running <= 1'h0;
		rd(8'h28, 32'h1, 32'h1);
		r1 = $urandom();
		aux_relay_state <= r1[3:0];
		open_collector_state <= r1[6:4];
		repeat (2) @(posedge ref_clk);
		rd(8'h00, {25'h0, r1[6:0]}, 32'hFF);
		wr(8'h14, 32'h00C8000D);
		wr(8'h14, 32'h00C8000E);
		rd(8'h14, 32'h5, 32'h7);
		process_value <= 16'h32;
		repeat (4) @(posedge ref_clk);
		rd(8'h30, 32'h64, 32'hFFFF);
		wr(8'h14, 32'h00C80003);
		rd(8'h14, 32'h0, 32'h7);
		wr(8'h18, 32'h04B106FB);
		rd(8'h18, 32'h00050301);
		wr(8'h18, 32'h000215FA);
		rd(8'h18, 32'h000215FA);
		r1 = $urandom();
		r2 = $urandom();
		multi_input_pins <= r1[7:0];
		extension_input_pins <= r1[10:8];
		wr(8'h04, {21'h0, r2[10:0]});
		repeat (40) @(posedge ref_clk);
		rd(8'h2C, {24'h0, r1[7:0] ^ r2[7:0]}, 32'h7FF);
		sub_board_present <= 1'h1;
		repeat (40) @(posedge ref_clk);
		rd(8'h2C, {21'h0, r1[10:0] ^ r2[10:0]}, 32'h7FF);
		// with multi-step on, a changed input waits out the check time
		multi_step_active <= 1'h1;
		multi_input_pins <= ~r1[7:0];
		rd(8'h2C, {21'h0, r1[10:0] ^ r2[10:0]}, 32'h7FF);
		r1[7:0] = ~r1[7:0];
		repeat (40) @(posedge ref_clk);
		rd(8'h2C, {21'h0, r1[10:0] ^ r2[10:0]}, 32'h7FF);
		motor_temp <= 9'h6D;
		repeat (4) @(posedge ref_clk);
		rd(8'h28, 32'h0, 32'h20);
		wr(8'h08, 32'h6);
		motor_temp <= 9'h6E;
		rd(8'h28, 32'h0, 32'h20);
		wr(8'h08, 32'h1);
		repeat (4) @(posedge ref_clk);
		rd(8'h28, 32'h20, 32'h20);
		heatsink_overheat <= 1'h1;
		repeat (4) @(posedge ref_clk);
		rd(8'h28, 32'h40, 32'h40);
		serial_cmd_source <= 1'h1;
		wr(8'h1C, 32'h1);
		repeat (1300) @(posedge ref_clk);
		rd(8'h28, 32'h0E, 32'h1E);
		wr(8'h18, 32'h000225FA);
		rd(8'h28, 32'h16, 32'h1E);
		wr(8'h18, 32'h000205FA);
		rd(8'h28, 32'h06, 32'h1E);
		send <= 1'h1;
		@(posedge ref_clk);
		send <= 1'h0;
		repeat (60) @(posedge ref_clk);
		rd(8'h28, 32'h0, 32'h84);
		repeat (40) @(posedge ref_clk);
		rd(8'h28, 32'h80, 32'h80);
		wr(8'h20, 32'h1);
		fault_active <= 1'h1;
		repeat (500) @(posedge ref_clk);
		rd(8'h00, 32'h0, 32'h80);
		repeat (800) @(posedge ref_clk);
		rd(8'h00, 32'h80, 32'h80);
		fault_active <= 1'h0;
		repeat (5) @(posedge ref_clk);
		rd(8'h00, 32'h0, 32'h80);
		end_sim();
	end
endmodule // tb_top
`default_nettype wire
